// ===== rtl/ssf_pkg.sv
// shared constants and types of the frame-sync and compare block
package ssf_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int BIT_HZ = 3_125_000;
	localparam int BIT_DIV = CLK_HZ / BIT_HZ;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] BIT_DIV_M1 = DIV_W'(BIT_DIV - 1);

	// ****************************************
	// widths
	// ****************************************
	localparam int LEN_W = 8;
	localparam int CNT_W = 9;
	localparam int PER_W = 8;
	localparam int HIST_W = 256;
	localparam int DATA_W = 8;
	localparam int SHOLD_W = 32;
	localparam int SHOLD_IW = 5;
	localparam int STAT_W = 5;
	localparam logic [LEN_W-1:0] LEN_MAX = 8'hFF;
	localparam logic [2:0] DATA_LAST = 3'h7;
	localparam logic [CNT_W-1:0] DATA_LAST_CNT = 9'h007;
	localparam logic [CNT_W-1:0] SHOLD_CNT = 9'h020;

	// ****************************************
	// output shapes of a frame pin
	// ****************************************
	localparam logic [2:0] FS_NONE = 3'h0;
	localparam logic [2:0] FS_NEG_PULSE = 3'h1;
	localparam logic [2:0] FS_POS_PULSE = 3'h2;
	localparam logic [2:0] FS_LOW_DATA = 3'h3;
	localparam logic [2:0] FS_HIGH_DATA = 3'h4;
	localparam logic [2:0] FS_TOGGLE = 3'h5;

	// edge select: 0 rising, 1 falling
	localparam logic EDGE_RISE = 1'b0;

	// ****************************************
	// status bit positions
	// ****************************************
	localparam int ST_RX_SYNC = 0;
	localparam int ST_TX_SYNC = 1;
	localparam int ST_CMP0 = 2;
	localparam int ST_RX_RDY = 3;
	localparam int ST_TX_UNDER = 4;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [2:0] sync_output_shape;
		logic [LEN_W-1:0] sync_length;
		logic [PER_W-1:0] period;
		logic sync_edge_select;
	} ssf_frame_cfg_t;

	typedef struct packed {
		logic [PER_W:0] per_cnt;
		logic [CNT_W-1:0] ph_cnt;
		logic in_pulse;
		logic in_data;
		logic tog;
	} ssf_gen_t;

	typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_DATA} ssf_rx_st_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} ssf_tx_st_t;

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic tick;
		logic rxd_s1;
		logic rxd_s2;
		logic rf_s1;
		logic rf_s2;
		logic rf_d;
		logic tf_s1;
		logic tf_s2;
		logic tf_d;
		ssf_gen_t tg;
		ssf_gen_t rg;
		logic [HIST_W-1:0] hist;
		ssf_rx_st_t rx_st;
		logic [CNT_W-1:0] rx_cnt;
		logic [SHOLD_W-1:0] rx_sh;
		logic [SHOLD_W-1:0] rx_sync_hold;
		logic rx_sync_vld;
		logic [DATA_W-1:0] rx_word;
		logic rx_word_vld;
		ssf_tx_st_t tx_st;
		logic [CNT_W-1:0] tx_cnt;
		logic [DATA_W-1:0] tx_word;
		logic tx_data;
		logic take;
		logic [STAT_W-1:0] stat;
		logic irq;
		logic tf_o;
		logic tf_oe;
		logic rf_o;
		logic rf_oe;
	} ssf_state_t;
endpackage : ssf_pkg

// ===== rtl/ssf_buf2.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ns
module ssf_buf2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic [WIDTH-1:0] d0;
		logic [WIDTH-1:0] d1;
		logic [1:0] cnt;
		logic vld;
		logic rdy;
	} ssf_buf_st_t;

	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_TWO = 2'h2;

	ssf_buf_st_t st;
	ssf_buf_st_t nxt;
	logic push;
	logic pop;

	// handshakes use the registered flags, so a full buffer never overwrites
	assign push = in_valid & st.rdy;
	assign pop = out_ready & st.vld;

	// entry move and count
	always_comb begin
		nxt = st;
		unique case ({push, pop})
			2'b10: begin
				if (st.cnt == '0) begin
					nxt.d0 = in_data;
				end else begin
					nxt.d1 = in_data;
				end
				nxt.cnt = st.cnt + CNT_ONE;
			end
			2'b01: begin
				nxt.d0 = st.d1;
				nxt.cnt = st.cnt - CNT_ONE;
			end
			2'b11: begin
				// push only possible below two, so head is replaced or shifted in
				if (st.cnt == CNT_ONE) begin
					nxt.d0 = in_data;
				end else begin
					nxt.d0 = st.d1;
					nxt.d1 = in_data;
				end
			end
			2'b00: begin
			end
		endcase
		nxt.vld = (nxt.cnt != '0);
		nxt.rdy = (nxt.cnt != CNT_TWO);
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
			st.rdy <= 1'b1;
		end else begin
			st <= nxt;
		end
	end

	assign in_ready = st.rdy;
	assign out_valid = st.vld;
	assign out_data = st.d0;
endmodule : ssf_buf2

// ===== rtl/ssf_top.sv
// frame-sync generation, sync data, edge flags and compare-0 start
//
// Functional notes
// R1: frame pins follow per-direction shape: level during data, pulse, or toggle.
// R2: pulse shapes last sync_length plus one bit times, one to 256.
// R3: frames repeat per direction at the period divider setting.
// R4: during sync, rx samples data into holding, tx shifts holding out.
// R5: bits sampled or shifted during sync equal the sync length plus one.
// R6: rx sync data reaches its holding register through the shift register.
// R7: tx sends sync data only when sync_data_enable is set.
// R8: normal data follows sync data, sync bits come from the holding register.
// R9: selected edge on a frame pin sets its sync-seen status flag.
// R10: compared bit count follows the sync length, at most 256.
// R11: compare always uses the most recently received bits.
// R12: with compare-0 start, every new sample is compared to the pattern.
// R13: each interrupt source has its own mask bit.
// R14: interrupt output high while any source is pending and unmasked.
// R15: status output reports which sources are pending.
// R16: compare-0 match while the receiver is idle starts a new data word at the next sample.
`timescale 1ns/1ns
module ssf_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// frame configuration
	input wire ssf_pkg::ssf_frame_cfg_t rx_frame_mode_reg,
	input wire ssf_pkg::ssf_frame_cfg_t tx_frame_mode_reg,
	input wire logic sync_data_enable,
	input wire logic rx_start_on_cmp0,
	input wire logic [ssf_pkg::HIST_W-1:0] compare_zero_pattern_reg,
	input wire logic [ssf_pkg::SHOLD_W-1:0] tx_sync_hold,
	// serial data pins
	input wire logic rx_data_pin,
	output logic tx_data_pin,
	// frame pins, two-way
	input wire logic tx_frame_pin_i,
	output logic tx_frame_pin_o,
	output logic tx_frame_pin_oe,
	input wire logic rx_frame_pin_i,
	output logic rx_frame_pin_o,
	output logic rx_frame_pin_oe,
	// transmit words
	input wire logic tx_word_valid,
	input wire logic [ssf_pkg::DATA_W-1:0] tx_word,
	output logic tx_word_ready,
	// received words and sync tag
	output logic [ssf_pkg::DATA_W-1:0] rx_word,
	output logic rx_word_valid,
	output logic [ssf_pkg::SHOLD_W-1:0] rx_sync_hold,
	output logic rx_sync_valid,
	// status and interrupt
	input wire logic [ssf_pkg::STAT_W-1:0] status_clear,
	input wire logic [ssf_pkg::STAT_W-1:0] irq_mask,
	output logic [ssf_pkg::STAT_W-1:0] serial_status_reg,
	output logic irq
);
	import ssf_pkg::*;

	ssf_state_t st;
	ssf_state_t nxt;
	logic buf_valid;
	logic [DATA_W-1:0] buf_data;

	// ****************************************
	// helper functions
	// ****************************************

	// true when the selected edge is seen between two synced samples
	function automatic logic edge_hit(input logic cur, input logic prev, input logic sel);
		if (sel == EDGE_RISE) begin
			return cur & ~prev;
		end
		return prev & ~cur;
	endfunction : edge_hit

	// a frame period begins when the counter runs out
	function automatic logic gen_start(input ssf_gen_t g, input ssf_frame_cfg_t c);
		return (c.period != '0) && (g.per_cnt == '0);
	endfunction : gen_start

	// one bit time of a frame generator
	function automatic ssf_gen_t gen_step(input ssf_gen_t g, input ssf_frame_cfg_t c);
		ssf_gen_t n;
		n = g;
		if (c.period == '0) begin
			// period zero means no frame is generated
			n.per_cnt = '0;
			n.in_pulse = 1'b0;
			n.in_data = 1'b0;
		end else if (g.per_cnt == '0) begin
			n.per_cnt = {c.period, 1'b1};
			n.in_pulse = 1'b1;
			n.in_data = 1'b0;
			n.ph_cnt = '0;
			n.tog = ~g.tog;
		end else begin
			n.per_cnt = g.per_cnt - (PER_W+1)'(1);
			if (g.in_pulse) begin
				if (g.ph_cnt == {1'b0, c.sync_length}) begin
					n.in_pulse = 1'b0;
					n.in_data = 1'b1;
					n.ph_cnt = '0;
				end else begin
					n.ph_cnt = g.ph_cnt + CNT_W'(1);
				end
			end else if (g.in_data) begin
				if (g.ph_cnt == DATA_LAST_CNT) begin
					n.in_data = 1'b0;
				end else begin
					n.ph_cnt = g.ph_cnt + CNT_W'(1);
				end
			end
		end
		return n;
	endfunction : gen_step

	// pin level for a shape; idle level of active-low shapes is high
	function automatic logic frame_level(input logic [2:0] shape, input ssf_gen_t g);
		unique case (shape)
			FS_NEG_PULSE: return ~g.in_pulse;
			FS_POS_PULSE: return g.in_pulse;
			FS_LOW_DATA: return ~g.in_data;
			FS_HIGH_DATA: return g.in_data;
			FS_TOGGLE: return g.tog;
			default: return 1'b0;
		endcase
	endfunction : frame_level

	// pattern equality over the newest sync_length plus one bits
	function automatic logic cmp_match(input logic [HIST_W-1:0] h,
		input logic [HIST_W-1:0] p, input logic [LEN_W-1:0] len);
		logic [HIST_W-1:0] m;
		m = {HIST_W{1'b1}} >> (LEN_MAX - len);
		return ((h ^ p) & m) == '0;
	endfunction : cmp_match

	// sync tag bit k, sent from bit sync_length down to bit zero
	function automatic logic sync_bit(input logic [SHOLD_W-1:0] hold,
		input logic [LEN_W-1:0] len, input logic [CNT_W-1:0] k);
		logic [CNT_W-1:0] i;
		i = {1'b0, len} - k;
		if (i < SHOLD_CNT) begin
			return hold[i[SHOLD_IW-1:0]];
		end
		return 1'b0;
	endfunction : sync_bit

	// ****************************************
	// transmit word buffer
	// ****************************************

	// the transmitter drains one word per frame, so a slow frame back-pressures the source
	ssf_buf2 #(
		.WIDTH(DATA_W)
	) u_tx_buf (
		.ref_clk(ref_clk),
		.srst(srst),
		.in_valid(tx_word_valid),
		.in_data(tx_word),
		.in_ready(tx_word_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(st.take)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [STAT_W-1:0] set;
		logic [HIST_W-1:0] hist_n;
		logic rf_edge;
		logic tf_edge;
		logic tx_start;
		logic cmp_hit;
		logic [SHOLD_W-1:0] sh_n;
		set = '0;
		rf_edge = 1'b0;
		tf_edge = 1'b0;
		tx_start = 1'b0;
		cmp_hit = 1'b0;
		sh_n = '0;
		hist_n = st.hist;
		nxt = st;
		nxt.take = 1'b0;
		nxt.rx_word_vld = 1'b0;
		nxt.rx_sync_vld = 1'b0;

		// two-flop synchronisers for every pin input
		nxt.rxd_s1 = rx_data_pin;
		nxt.rxd_s2 = st.rxd_s1;
		nxt.rf_s1 = rx_frame_pin_i;
		nxt.rf_s2 = st.rf_s1;
		nxt.rf_d = st.rf_s2;
		nxt.tf_s1 = tx_frame_pin_i;
		nxt.tf_s2 = st.tf_s1;
		nxt.tf_d = st.tf_s2;

		// bit-time enable from the reference clock
		nxt.tick = (st.div == BIT_DIV_M1);
		nxt.div = nxt.tick ? '0 : st.div + DIV_W'(1);

		// R9: edge sets flags
		rf_edge = edge_hit(st.rf_s2, st.rf_d, rx_frame_mode_reg.sync_edge_select);
		tf_edge = edge_hit(st.tf_s2, st.tf_d, tx_frame_mode_reg.sync_edge_select);
		set[ST_RX_SYNC] = rf_edge;
		set[ST_TX_SYNC] = tf_edge;

		// R3: periodic frame timing
		tx_start = st.tick && gen_start(st.tg, tx_frame_mode_reg);
		if (st.tick) begin
			// R2: pulse length count
			nxt.tg = gen_step(st.tg, tx_frame_mode_reg);
			nxt.rg = gen_step(st.rg, rx_frame_mode_reg);
		end

		// R1: frame pin waveform
		nxt.tf_o = frame_level(tx_frame_mode_reg.sync_output_shape, nxt.tg);
		nxt.tf_oe = (tx_frame_mode_reg.sync_output_shape != FS_NONE);
		nxt.rf_o = frame_level(rx_frame_mode_reg.sync_output_shape, nxt.rg);
		nxt.rf_oe = (rx_frame_mode_reg.sync_output_shape != FS_NONE);

		// R11: newest bit enters at the bottom
		if (st.tick) begin
			hist_n = {st.hist[HIST_W-2:0], st.rxd_s2};
			nxt.hist = hist_n;
		end
		// R10: compare length
		// R12: compare every sample
		cmp_hit = st.tick && rx_start_on_cmp0 &&
			cmp_match(hist_n, compare_zero_pattern_reg, rx_frame_mode_reg.sync_length);
		set[ST_CMP0] = cmp_hit;

		// receiver
		sh_n = {st.rx_sh[SHOLD_W-2:0], st.rxd_s2};
		unique case (st.rx_st)
			RX_IDLE: begin
				if (cmp_hit) begin
					// R16: match starts word
					nxt.rx_st = RX_DATA;
					nxt.rx_cnt = '0;
				end else if (!rx_start_on_cmp0 && rf_edge) begin
					nxt.rx_st = RX_SYNC;
					nxt.rx_cnt = '0;
					nxt.rx_sh = '0;
				end
			end
			RX_SYNC: begin
				if (st.tick) begin
					// R4: sample into holding
					nxt.rx_sh = sh_n;
					// R5: sync bit count
					if (st.rx_cnt == {1'b0, rx_frame_mode_reg.sync_length}) begin
						// R6: via shift register
						nxt.rx_sync_hold = sh_n;
						nxt.rx_sync_vld = 1'b1;
						nxt.rx_st = RX_DATA;
						nxt.rx_cnt = '0;
					end else begin
						nxt.rx_cnt = st.rx_cnt + CNT_W'(1);
					end
				end
			end
			RX_DATA: begin
				if (st.tick) begin
					nxt.rx_sh = sh_n;
					if (st.rx_cnt == DATA_LAST_CNT) begin
						nxt.rx_word = sh_n[DATA_W-1:0];
						nxt.rx_word_vld = 1'b1;
						set[ST_RX_RDY] = 1'b1;
						nxt.rx_st = RX_IDLE;
					end else begin
						nxt.rx_cnt = st.rx_cnt + CNT_W'(1);
					end
				end
			end
		endcase

		// transmitter; a new frame restarts it so it never drifts from the pin
		if (tx_start) begin
			nxt.tx_st = TX_SYNC;
			nxt.tx_cnt = '0;
			// R7: sync data gated
			nxt.tx_data = sync_data_enable &&
				sync_bit(tx_sync_hold, tx_frame_mode_reg.sync_length, '0);
		end else if (st.tick) begin
			unique case (st.tx_st)
				TX_IDLE: begin
					nxt.tx_data = 1'b0;
				end
				TX_SYNC: begin
					// R5: shifted bit count
					if (st.tx_cnt == {1'b0, tx_frame_mode_reg.sync_length}) begin
						// R8: normal data follows
						nxt.tx_st = TX_DATA;
						nxt.tx_cnt = '0;
						nxt.tx_word = buf_valid ? buf_data : '0;
						nxt.take = buf_valid;
						nxt.tx_data = buf_valid && buf_data[DATA_LAST];
						set[ST_TX_UNDER] = ~buf_valid;
					end else begin
						nxt.tx_cnt = st.tx_cnt + CNT_W'(1);
						// R4: holding to shifter
						nxt.tx_data = sync_data_enable &&
							sync_bit(tx_sync_hold, tx_frame_mode_reg.sync_length,
							nxt.tx_cnt);
					end
				end
				TX_DATA: begin
					if (st.tx_cnt == DATA_LAST_CNT) begin
						nxt.tx_st = TX_IDLE;
						nxt.tx_data = 1'b0;
					end else begin
						nxt.tx_cnt = st.tx_cnt + CNT_W'(1);
						nxt.tx_data = st.tx_word[DATA_LAST - nxt.tx_cnt[2:0]];
					end
				end
			endcase
		end

		// R15: pending sources, a set in the clear cycle wins
		nxt.stat = (st.stat & ~status_clear) | set;
		// R13: per-source mask
		// R14: any pending unmasked
		nxt.irq = |(nxt.stat & irq_mask);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	// ****************************************
	// outputs, all from flops
	// ****************************************
	assign tx_data_pin = st.tx_data;
	assign tx_frame_pin_o = st.tf_o;
	assign tx_frame_pin_oe = st.tf_oe;
	assign rx_frame_pin_o = st.rf_o;
	assign rx_frame_pin_oe = st.rf_oe;
	assign rx_word = st.rx_word;
	assign rx_word_valid = st.rx_word_vld;
	assign rx_sync_hold = st.rx_sync_hold;
	assign rx_sync_valid = st.rx_sync_vld;
	assign serial_status_reg = st.stat;
	assign irq = st.irq;
endmodule : ssf_top

// ===== test/ssf_peer.sv
// serial peer model: sends frame-tagged bit strings on the receive lines
`timescale 1ns/1ns
module ssf_peer (
	// clock and start request
	input wire logic ref_clk,
	input wire logic go,
	// transmit frame wire, used only to align bit edges
	input wire logic tf,
	// string to send, msb first, frame high for the first sbits bits
	input wire logic [5:0] sbits,
	input wire logic [5:0] nbits,
	input wire logic [39:0] bits,
	// receive data and frame lines
	output logic rxd,
	output logic rfs
);
	logic tf_d = 1'b0;
	logic armed = 1'b0;
	int k = 0;
	int ph = 0;
	initial rxd = 1'b0;
	initial rfs = 1'b0;
	// bits change one cycle after a frame tick so they are stable at the sampling tick
	always @(posedge ref_clk) begin
		tf_d <= tf;
		if (go) begin
			armed <= 1'b1;
		end else if (armed && tf && !tf_d) begin
			armed <= 1'b0;
			k <= 1;
			ph <= 0;
			rxd <= bits[nbits-1];
			rfs <= (sbits != 6'h00);
		end else if (k > 0) begin
			ph <= (ph == 7) ? 0 : ph + 1;
			if (ph == 7 && k == nbits) begin
				// released line shows the inverse of its last bit, not a held copy
				k <= 0;
				rxd <= ~rxd;
				rfs <= 1'b0;
			end else if (ph == 7) begin
				rxd <= bits[nbits-1-k];
				rfs <= (k < sbits);
				k <= k + 1;
			end
		end
	end
endmodule : ssf_peer

// ===== test/ssf_top_properties.sv
// port-level assertions of the frame-sync block
`timescale 1ns/1ns
module ssf_top_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// configuration
	input wire ssf_pkg::ssf_frame_cfg_t tx_frame_mode_reg,
	input wire ssf_pkg::ssf_frame_cfg_t rx_frame_mode_reg,
	input wire logic [ssf_pkg::STAT_W-1:0] irq_mask,
	input wire logic [ssf_pkg::STAT_W-1:0] status_clear,
	// watched outputs and pins
	input wire logic tx_frame_pin_i,
	input wire logic tx_frame_pin_o,
	input wire logic tx_frame_pin_oe,
	input wire logic rx_frame_pin_oe,
	input wire logic tx_word_ready,
	input wire logic rx_word_valid,
	input wire logic rx_sync_valid,
	input wire logic [ssf_pkg::STAT_W-1:0] serial_status_reg,
	input wire logic irq
);
	import ssf_pkg::*;
	// ****
	// high time and frame spacing counters
	// ****
	logic [11:0] hi_cnt_r;
	logic [11:0] per_cnt_r;
	logic tf_d_r;
	logic seen_r;
	always_ff @(posedge ref_clk) begin
		tf_d_r <= srst ? 1'b0 : tx_frame_pin_o;
		hi_cnt_r <= (srst || !tx_frame_pin_o) ? 12'h000 : hi_cnt_r + 12'h001;
		per_cnt_r <= (tx_frame_pin_o && !tf_d_r) ? 12'h001 : per_cnt_r + 12'h001;
		seen_r <= srst ? 1'b0 : (seen_r || (tx_frame_pin_o && !tf_d_r));
	end
	a_irq_follows: assert property (
		@(posedge ref_clk) disable iff (srst)
		irq == |(serial_status_reg & $past(irq_mask)))
		else $error("irq differs from masked status");
	a_status_sticky: assert property (
		@(posedge ref_clk) disable iff (srst)
		($past(serial_status_reg) & ~$past(status_clear) & ~serial_status_reg) == 5'h00)
		else $error("status bit lost without clear");
	a_oe_shape: assert property (
		@(posedge ref_clk) disable iff (srst)
		!$past(srst) |-> tx_frame_pin_oe == ($past(tx_frame_mode_reg.sync_output_shape) != 3'h0)
		&& rx_frame_pin_oe == ($past(rx_frame_mode_reg.sync_output_shape) != 3'h0))
		else $error("frame pin enable does not follow shape");
	a_pulse_len: assert property (
		@(posedge ref_clk) disable iff (srst)
		$fell(tx_frame_pin_o) && tx_frame_mode_reg.sync_output_shape == FS_POS_PULSE
		|-> hi_cnt_r == ({4'h0, tx_frame_mode_reg.sync_length} + 12'h001) << 3)
		else $error("sync pulse length wrong");
	a_frame_period: assert property (
		@(posedge ref_clk) disable iff (srst)
		tx_frame_pin_o && !tf_d_r && seen_r && tx_frame_mode_reg.sync_output_shape == FS_POS_PULSE
		|-> per_cnt_r == ({4'h0, tx_frame_mode_reg.period} + 12'h001) << 4)
		else $error("frame period wrong");
	a_tx_sync_flag: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(tx_frame_pin_i) && tx_frame_mode_reg.sync_edge_select == EDGE_RISE
		|-> ##[1:6] serial_status_reg[ST_TX_SYNC])
		else $error("tx sync edge not flagged");
	a_word_spacing: assert property (
		@(posedge ref_clk) disable iff (srst)
		rx_word_valid |=> (!rx_word_valid) [*8])
		else $error("received words too close");
	a_sync_then_word: assert property (
		@(posedge ref_clk) disable iff (srst)
		rx_sync_valid |-> ##[56:72] rx_word_valid)
		else $error("word missing after sync tag");
	a_underrun_empty: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(serial_status_reg[ST_TX_UNDER]) |-> $past(tx_word_ready))
		else $error("underrun while buffer full");
endmodule : ssf_top_props
bind ssf_top ssf_top_props u_props (.ref_clk, .srst, .tx_frame_mode_reg, .rx_frame_mode_reg,
	.irq_mask, .status_clear, .tx_frame_pin_i, .tx_frame_pin_o, .tx_frame_pin_oe,
	.rx_frame_pin_oe, .tx_word_ready, .rx_word_valid, .rx_sync_valid, .serial_status_reg, .irq);

// ===== test/ssf_top_tb.sv
// self-checking bench of the frame-sync block
`timescale 1ns/1ns
module ssf_top_tb;
	import ssf_pkg::*;
	// ****
	// stimulus and design signals
	// ****
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	ssf_frame_cfg_t rx_frame_mode_reg = '{FS_NONE, 8'h03, 8'h07, EDGE_RISE};
	ssf_frame_cfg_t tx_frame_mode_reg = '{FS_POS_PULSE, 8'h03, 8'h07, EDGE_RISE};
	logic sync_data_enable = 1'b0;
	logic rx_start_on_cmp0 = 1'b0;
	logic [HIST_W-1:0] compare_zero_pattern_reg = {252'h0, 4'hA};
	logic [SHOLD_W-1:0] tx_sync_hold = 32'h0000_0000;
	logic tx_word_valid = 1'b0;
	logic [DATA_W-1:0] tx_word = 8'h00;
	logic [STAT_W-1:0] status_clear = 5'h00;
	logic [STAT_W-1:0] irq_mask = 5'h00;
	logic rx_data_pin, tx_data_pin, tx_frame_pin_o, tx_frame_pin_oe, rx_frame_pin_o;
	logic rx_frame_pin_oe, tx_word_ready, rx_word_valid, rx_sync_valid, irq, rfs;
	logic tx_frame_pin_i, rx_frame_pin_i, rf_prev;
	logic [DATA_W-1:0] rx_word;
	logic [SHOLD_W-1:0] rx_sync_hold;
	logic [STAT_W-1:0] serial_status_reg;
	logic go = 1'b0;
	logic [5:0] sbits = 6'h00;
	logic [5:0] nbits = 6'h0C;
	logic [39:0] pbits = 40'h0;
	logic [11:0] v;
	logic [7:0] w0, w1;
	logic [3:0] s;
	int miscompares = 0;
	int samples_checked = 0;
	int n;
	always #20 ref_clk = ~ref_clk;
	// frame wires: the driving party wins, the tx wire is pulled low when released
	assign tx_frame_pin_i = tx_frame_pin_oe ? tx_frame_pin_o : 1'b0;
	assign rx_frame_pin_i = rx_frame_pin_oe ? rx_frame_pin_o : rfs;
	ssf_top uut (.ref_clk, .srst, .rx_frame_mode_reg, .tx_frame_mode_reg, .sync_data_enable,
		.rx_start_on_cmp0, .compare_zero_pattern_reg, .tx_sync_hold, .rx_data_pin, .tx_data_pin,
		.tx_frame_pin_i, .tx_frame_pin_o, .tx_frame_pin_oe, .rx_frame_pin_i, .rx_frame_pin_o,
		.rx_frame_pin_oe, .tx_word_valid, .tx_word, .tx_word_ready, .rx_word, .rx_word_valid,
		.rx_sync_hold, .rx_sync_valid, .status_clear, .irq_mask, .serial_status_reg, .irq);
	ssf_peer u_peer (.ref_clk, .go, .tf(tx_frame_pin_i), .sbits, .nbits, .bits(pbits),
		.rxd(rx_data_pin), .rfs);
	// ****
	// checking helpers
	// ****
	task automatic give_verdict;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic ok, input string what);
		samples_checked++;
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : check
	// expected tx frame: sync tag msb first (zeros when disabled), then the word
	function automatic logic [11:0] exp_tx(input logic en, input logic [31:0] h,
		input logic [7:0] w);
		return {en ? h[3:0] : 4'h0, w};
	endfunction : exp_tx
	// samples a tx frame in mid-bit, from the rise of the frame pin
	task automatic capture(output logic [11:0] q);
		int c;
		c = 0;
		while (tx_frame_pin_o !== 1'b0 && c < 400) begin
			@(negedge ref_clk);
			c++;
		end
		while (tx_frame_pin_o !== 1'b1 && c < 400) begin
			@(negedge ref_clk);
			c++;
		end
		if (c >= 400) begin
			check(1'b0, "no tx frame");
			give_verdict();
		end
		repeat (4) @(negedge ref_clk);
		for (int i = 11; i >= 0; i--) begin
			q[i] = tx_data_pin;
			repeat (8) @(negedge ref_clk);
		end
	endtask : capture
	task automatic drive_at(input logic [STAT_W-1:0] m, input logic [STAT_W-1:0] c);
		@(posedge ref_clk);
		irq_mask <= m;
		status_clear <= c;
		@(posedge ref_clk);
		status_clear <= 5'h00;
		@(negedge ref_clk);
	endtask : drive_at
	task automatic wait_rx(input logic [7:0] w);
		int c;
		c = 0;
		while (rx_word_valid !== 1'b1 && c < 600) begin
			@(negedge ref_clk);
			c++;
		end
		check(c < 600 && rx_word === w, "received word differs");
		if (c >= 600) begin
			give_verdict();
		end
	endtask : wait_rx
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(42));
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		check(serial_status_reg === 5'h00 && irq === 1'b0 && tx_word_ready === 1'b1, "reset");
		for (int j = 0; j < 3; j++) begin
			w0 = 8'($urandom);
			w1 = 8'($urandom);
			@(posedge ref_clk);
			sync_data_enable <= j[0];
			tx_sync_hold <= $urandom;
			capture(v);
			// two words fill the buffer; valid drops only after an accepting edge
			@(posedge ref_clk);
			tx_word_valid <= 1'b1;
			tx_word <= w0;
			@(posedge ref_clk);
			tx_word <= w1;
			@(posedge ref_clk);
			tx_word_valid <= 1'b0;
			@(negedge ref_clk);
			check(tx_word_ready === 1'b0, "buffer not full");
			capture(v);
			check(v === exp_tx(sync_data_enable, tx_sync_hold, w0), "first frame");
			capture(v);
			check(v === exp_tx(sync_data_enable, tx_sync_hold, w1), "second frame");
			drive_at(5'h01, 5'h10);
			check(irq === 1'b0 && serial_status_reg[ST_TX_UNDER] === 1'b0, "clear");
			capture(v);
			check(v === exp_tx(sync_data_enable, tx_sync_hold, 8'h00), "empty frame");
			drive_at(5'h10, 5'h00);
			check(irq === 1'b1 && serial_status_reg === 5'h12, "underrun pending");
		end
		for (int j = 0; j < 4; j++) begin
			s = 4'($urandom);
			w0 = 8'($urandom);
			@(posedge ref_clk);
			rx_start_on_cmp0 <= j[0];
			// falling edge select on the third run, so the start comes at the frame's end
			rx_frame_mode_reg.sync_edge_select <= j[1];
			// pattern bits above the sync length must not matter
			compare_zero_pattern_reg[35:4] <= $urandom;
			sbits <= j[0] ? 6'h00 : 6'h04;
			nbits <= (j == 2) ? 6'h10 : 6'h0C;
			// on the falling-edge run four filler bits go out while the frame line is high
			pbits <= {24'h0, ~s, j[0] ? 4'hA : s, w0};
			go <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
			wait_rx(w0);
			if (j[0]) begin
				check(serial_status_reg[ST_CMP0] === 1'b1, "no compare match");
				check(rx_word === w0, "word not aligned to newest bits");
			end else begin
				check(rx_sync_hold[3:0] === s && serial_status_reg[ST_RX_SYNC] === 1'b1,
					"sync tag");
			end
			repeat (150) @(negedge ref_clk);
		end
		@(posedge ref_clk);
		rx_start_on_cmp0 <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			@(posedge ref_clk);
			rx_frame_mode_reg.sync_output_shape <= 3'(k);
			n = 0;
			rf_prev = rx_frame_pin_o;
			repeat (300) begin
				@(negedge ref_clk);
				n += int'(rx_frame_pin_o !== rf_prev);
				rf_prev = rx_frame_pin_o;
			end
			check(rx_frame_pin_oe === (k != 0) && (k == 0 || n > 0), "frame shape");
		end
		give_verdict();
	end
endmodule : ssf_top_tb
